// ===== logic/pss_pkg.sv
// constants, types and field layout of the transceiver status and identifier registers
// Function
// - capability bits 14 and 13 read one, bits 15 and 10 read zero
// - 10 Mbit capability bits 12 and 11 read one in twisted pair, zero in fiber
// - bit 6 reads one; frames without preamble accepted after first preamble
// - bit 5 shows auto-negotiation complete when enabled; always zero in fiber
// - bit 4 latches one on partner remote fault or far-end fault
// - status read releases latched remote fault; then bit shows current condition
// - bit 3 reads one in twisted pair, zero in fiber
// - bit 2 follows link; any loss latches zero until status read
// - bit 1 latches one on jabber; status read releases it, then bit shows current jabber condition
// - bit 0 reads one for extended register set
package pss_pkg;
  // register indices on the management interface
  localparam logic [4:0] REG_STATUS_IDX = 5'h01;
  localparam logic [4:0] REG_IDENT_HIGH_IDX = 5'h02;
  localparam logic [15:0] STATUS_RESET = 16'h7849;
  // status field positions
  localparam int BIT_CAP_100_T4 = 15;
  localparam int BIT_CAP_100_FULL = 14;
  localparam int BIT_CAP_100_HALF = 13;
  localparam int BIT_CAP_10_FULL = 12;
  localparam int BIT_CAP_10_HALF = 11;
  localparam int BIT_CAP_100_T2 = 10;
  localparam int BIT_PREAMBLE_SUPPRESS = 6;
  localparam int BIT_AUTONEG_DONE = 5;
  localparam int BIT_REMOTE_FAULT = 4;
  localparam int BIT_AUTONEG_CAPABLE = 3;
  localparam int BIT_LINK = 2;
  localparam int BIT_JABBER = 1;
  localparam int BIT_EXTENDED = 0;
  // management frame layout
  localparam logic [5:0] PREAMBLE_BITS = 6'h20;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [3:0] OP_LAST = 4'h1;
  localparam logic [3:0] ADDR_LAST = 4'h9;
  localparam logic [3:0] TA_LAST = 4'h1;
  localparam logic [3:0] DATA_LAST = 4'hF;
  localparam logic [15:0] READ_ZERO = 16'h0000;
  // synchroniser reset levels for management clock and data
  localparam logic MDC_IDLE = 1'b0;
  localparam logic MDIO_IDLE = 1'b1;

  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_OP, ST_ADDR, ST_TA, ST_DATA} pss_state_e;

  // line-side conditions, from logic on the same clock
  typedef struct packed {
    logic fiber_mode;
    logic autoneg_en;
    logic autoneg_done;
    logic link_up;
    logic jabber;
    logic partner_remote_fault;
    logic far_end_fault;
  } pss_line_s;
endpackage

// ===== logic/pss_status_regs.sv
// status and first identifier registers behind the serial management interface
`timescale 1ns/100ps

// three-stage synchroniser, output follows once stages two and three agree
module pss_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // signal
  input wire logic d_i,
  output logic q_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // sampling chain
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // accept a change only once it has settled
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      q_o <= RESET_VAL;
    end else if (s2_q == s3_q) begin
      q_o <= s3_q;
    end
  end
endmodule

module pss_status_regs #(
  parameter logic [15:0] IDENT_HIGH = 16'h1A5C // arbitrary value
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // management pins
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  // configuration and line conditions
  input wire logic [4:0] phy_addr_i,
  input wire pss_pkg::pss_line_s line_i,
  // visible status word
  output logic [15:0] status_o
);
  import pss_pkg::*;

  logic mdc_s;
  logic mdio_s;
  logic mdc_prev_q;
  logic rise;
  pss_state_e state_q;
  logic [3:0] cnt_q;
  logic [1:0] op_q;
  logic [9:0] addr_q;
  logic [15:0] tx_q;
  logic [5:0] ones_q;
  logic preamble_seen_q;
  logic prev_bit_q;
  logic rd_hit_q;
  logic status_rd;
  logic [9:0] addr_d;
  logic rf_cond;
  logic rf_q;
  logic link_q;
  logic jab_q;
  logic [15:0] status_word;
  logic [15:0] read_word;

  // pin synchronisers
  pss_sync #(.RESET_VAL(MDC_IDLE)) u_mdc_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .d_i(mdc_i),
    .q_o(mdc_s)
  );
  pss_sync #(.RESET_VAL(MDIO_IDLE)) u_mdio_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .d_i(mdio_i),
    .q_o(mdio_s)
  );

  // management clock rising edge
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      mdc_prev_q <= MDC_IDLE;
    end else begin
      mdc_prev_q <= mdc_s;
    end
  end
  assign rise = mdc_s && !mdc_prev_q;
  assign addr_d = {addr_q[8:0], mdio_s};
  // status read strobe at the end of the register address
  assign status_rd = rise && (state_q == ST_ADDR) && (cnt_q == ADDR_LAST) && (op_q == OP_READ) &&
                     (addr_d[9:5] == phy_addr_i) && (addr_d[4:0] == REG_STATUS_IDX);

  // preamble counting, needed once after reset
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ones_q <= 6'h00;
      preamble_seen_q <= 1'b0;
    end else if (rise && state_q == ST_IDLE) begin
      if (!mdio_s) begin
        ones_q <= 6'h00;
      end else if (ones_q != PREAMBLE_BITS) begin
        ones_q <= ones_q + 6'h01;
      end
      if (mdio_s && ones_q == PREAMBLE_BITS - 6'h01) begin
        preamble_seen_q <= 1'b1;
      end
    end
  end

  // last sampled bit; frame end counts as no idle bit yet
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      prev_bit_q <= 1'b0;
    end else if (rise) begin
      prev_bit_q <= (state_q == ST_DATA && cnt_q == DATA_LAST) ? 1'b0 : mdio_s;
    end
  end

  // frame state machine
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      op_q <= 2'h0;
      addr_q <= 10'h000;
      rd_hit_q <= 1'b0;
    end else if (rise) begin
      unique case (state_q)
        ST_IDLE: begin
          // start after an idle bit; no preamble needed once one was seen
          if (!mdio_s && prev_bit_q && preamble_seen_q) begin
            state_q <= ST_START;
          end
        end
        ST_START: begin
          state_q <= mdio_s ? ST_OP : ST_IDLE;
          cnt_q <= 4'h0;
        end
        ST_OP: begin
          op_q <= {op_q[0], mdio_s};
          cnt_q <= (cnt_q == OP_LAST) ? 4'h0 : cnt_q + 4'h1;
          if (cnt_q == OP_LAST) begin
            state_q <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          addr_q <= addr_d;
          cnt_q <= (cnt_q == ADDR_LAST) ? 4'h0 : cnt_q + 4'h1;
          if (cnt_q == ADDR_LAST) begin
            state_q <= ST_TA;
            rd_hit_q <= (op_q == OP_READ) && (addr_d[9:5] == phy_addr_i);
          end
        end
        ST_TA: begin
          cnt_q <= (cnt_q == TA_LAST) ? 4'h0 : cnt_q + 4'h1;
          if (cnt_q == TA_LAST) begin
            state_q <= ST_DATA;
          end
        end
        ST_DATA: begin
          // write data is consumed and dropped
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == DATA_LAST) begin
            state_q <= ST_IDLE;
            rd_hit_q <= 1'b0;
          end
        end
      endcase
    end
  end

  // read data select
  always_comb begin
    read_word = READ_ZERO;
    if (addr_d[4:0] == REG_STATUS_IDX) begin
      read_word = status_word;
    end else if (addr_d[4:0] == REG_IDENT_HIGH_IDX) begin
      read_word = IDENT_HIGH;
    end
  end

  // read shifter and pin drive, changed just after the rising edge
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      tx_q <= 16'h0000;
      mdio_o <= 1'b0;
      mdio_oe_o <= 1'b0;
    end else if (rise) begin
      if (state_q == ST_ADDR && cnt_q == ADDR_LAST) begin
        tx_q <= read_word;
      end else if (state_q == ST_TA && cnt_q == 4'h0) begin
        mdio_oe_o <= rd_hit_q;
        mdio_o <= 1'b0;
      end else if ((state_q == ST_TA && cnt_q == TA_LAST) || (state_q == ST_DATA && cnt_q != DATA_LAST)) begin
        mdio_o <= tx_q[15];
        tx_q <= {tx_q[14:0], 1'b0};
      end else if (state_q == ST_DATA) begin
        mdio_oe_o <= 1'b0;
      end
    end
  end

  // latched conditions; a new event beats the release by a read
  assign rf_cond = line_i.partner_remote_fault || line_i.far_end_fault;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rf_q <= 1'b0;
    end else begin
      rf_q <= rf_cond || (rf_q && !status_rd);
    end
  end
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      link_q <= 1'b0;
    end else begin
      link_q <= line_i.link_up && (link_q || status_rd);
    end
  end
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      jab_q <= 1'b0;
    end else begin
      jab_q <= line_i.jabber || (jab_q && !status_rd);
    end
  end

  // status word assembly
  always_comb begin
    status_word = 16'h0000;
    status_word[BIT_CAP_100_T4] = 1'b0;
    status_word[BIT_CAP_100_FULL] = 1'b1;
    status_word[BIT_CAP_100_HALF] = 1'b1;
    status_word[BIT_CAP_10_FULL] = !line_i.fiber_mode;
    status_word[BIT_CAP_10_HALF] = !line_i.fiber_mode;
    status_word[BIT_CAP_100_T2] = 1'b0;
    status_word[BIT_PREAMBLE_SUPPRESS] = 1'b1;
    status_word[BIT_AUTONEG_DONE] = !line_i.fiber_mode && line_i.autoneg_en && line_i.autoneg_done;
    status_word[BIT_REMOTE_FAULT] = rf_q;
    status_word[BIT_AUTONEG_CAPABLE] = !line_i.fiber_mode;
    status_word[BIT_LINK] = link_q;
    status_word[BIT_JABBER] = jab_q;
    status_word[BIT_EXTENDED] = 1'b1;
  end

  // visible status copy
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      status_o <= STATUS_RESET;
    end else begin
      status_o <= status_word;
    end
  end

  // checks
  cap_fixed_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    status_word[15:13] == 3'h3 && !status_word[10]) else $error("fixed capability bits wrong");
  cap_mode_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    status_word[12:11] == {2{!line_i.fiber_mode}} && status_word[3] == !line_i.fiber_mode)
    else $error("mode capability bits wrong");
  no_preamble_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    rise && state_q == ST_IDLE && !mdio_s && prev_bit_q && preamble_seen_q |=> state_q == ST_START)
    else $error("frame start not taken");
  early_frame_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !preamble_seen_q |-> state_q == ST_IDLE) else $error("frame taken before preamble");
  an_done_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    line_i.fiber_mode |-> !status_word[5]) else $error("autoneg done in fiber mode");
  rf_latch_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    rf_cond |=> status_word[4]) else $error("remote fault not latched");
  rf_release_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    status_rd && !rf_cond |=> !rf_q) else $error("remote fault not released");
  link_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !line_i.link_up ##1 !status_rd [*3] |-> !link_q) else $error("link loss not held");
  jab_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    jab_q && !status_rd |=> jab_q) else $error("jabber flag dropped");
  read_drive_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    mdio_oe_o |-> rd_hit_q && (state_q == ST_TA || state_q == ST_DATA)) else $error("pin driven outside read");
  fixed_bits_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    status_word[9:6] == 4'h1 && status_word[0]) else $error("fixed status bits wrong");
  jab_latch_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    line_i.jabber |=> jab_q) else $error("jabber not latched");
  link_follow_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    status_rd && line_i.link_up |=> link_q) else $error("link not shown after read");
  link_back_c: cover property (@(posedge clock_i) disable iff (!rst_n_i) !link_q && status_rd ##1 link_q);
  rd_frame_c: cover property (@(posedge clock_i) disable iff (!rst_n_i) status_rd ##[1:400] !mdio_oe_o);
  wr_frame_c: cover property (@(posedge clock_i) disable iff (!rst_n_i) state_q == ST_DATA && op_q == OP_WRITE);
  rf_clear_c: cover property (@(posedge clock_i) disable iff (!rst_n_i) rf_q ##1 status_rd ##1 !rf_q);
endmodule

// ===== bench/pss_mgmt_ctrl.sv
// management controller model driving clause-22 frames on mdc and mdio
`timescale 1ns/100ps
module pss_mgmt_ctrl (
  // clock
  input wire logic clock_i,
  // device side of the data pin
  input wire logic dev_mdio_i,
  input wire logic dev_oe_i,
  // management pins
  output logic mdc_o,
  output logic mdio_o
);
  import pss_pkg::*;
  logic drv_oe;
  logic drv_d;
  // pull-up holds the pin high while nobody drives it
  assign mdio_o = dev_oe_i ? dev_mdio_i : (drv_oe ? drv_d : 1'b1);
  initial begin
    mdc_o = 1'b0;
    drv_oe = 1'b0;
    drv_d = 1'b1;
  end
  // one bit: data set with falling mdc, pin sampled as mdc rises
  task automatic bit_cycle(input logic oe, input logic d, output logic s);
    @(posedge clock_i);
    #1;
    mdc_o = 1'b0;
    drv_oe = oe;
    drv_d = d;
    repeat (8) @(posedge clock_i);
    #1;
    s = mdio_o;
    mdc_o = 1'b1;
    repeat (7) @(posedge clock_i);
  endtask
  // whole frame; pre gives the count of preamble ones
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, input int pre, output logic [15:0] rd);
    logic [13:0] hdr;
    logic s;
    hdr = {2'h1, op, pa, ra};
    rd = 16'h0000;
    for (int i = 0; i < pre; i++) bit_cycle(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bit_cycle(1'b1, hdr[i], s);
    // turnaround: released on a read, driven 1 then 0 on a write
    for (int i = 1; i >= 0; i--) bit_cycle(op != OP_READ, i[0], s);
    for (int i = 15; i >= 0; i--) begin
      bit_cycle(op != OP_READ, wd[i], s);
      rd[i] = s;
    end
    bit_cycle(1'b0, 1'b1, s);
  endtask
endmodule

// ===== bench/tb_pss_status_regs.sv
// self-checking bench for the status and identifier registers
`timescale 1ns/100ps
module tb_pss_status_regs;
  import pss_pkg::*;
  localparam logic [15:0] IDENT = 16'h2B7E; // arbitrary value
  localparam logic [4:0] ADDR = 5'h05;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic mdc;
  logic pin;
  logic dut_mdio;
  logic dut_oe;
  logic [15:0] status;
  logic [15:0] d;
  pss_line_s line = 7'h38;
  int err_total = 0;
  int tests_run = 0;
  always #4 clock_i = ~clock_i;
  pss_status_regs #(.IDENT_HIGH(IDENT)) u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .mdc_i(mdc),
    .mdio_i(pin), .mdio_o(dut_mdio), .mdio_oe_o(dut_oe), .phy_addr_i(ADDR), .line_i(line), .status_o(status));
  pss_mgmt_ctrl u_mgr (.clock_i(clock_i), .dev_mdio_i(dut_mdio), .dev_oe_i(dut_oe), .mdc_o(mdc), .mdio_o(pin));
  // compare one 16-bit word
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // read a register and compare it
  task automatic rd_chk(input logic [4:0] pa, input logic [4:0] ra, input int pre, input logic [15:0] exp);
    logic [15:0] r;
    u_mgr.frame(OP_READ, pa, ra, 16'h0000, pre, r);
    chk16(r, exp);
  endtask
  // expected status word for the present mode
  function automatic logic [15:0] stat(input logic an, input logic rf, input logic lk, input logic jb);
    return {3'h3, ~line.fiber_mode, ~line.fiber_mode, 4'h0, 1'b1, an, rf, ~line.fiber_mode, lk, jb, 1'b1};
  endfunction
  // line conditions change just after an edge
  task automatic set_line(input logic [6:0] v);
    @(posedge clock_i);
    #1 line = v;
  endtask
  task automatic wrap_up;
    if (err_total == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // watchdog against a hung frame
  initial begin
    repeat (40000) @(posedge clock_i);
    err_total++;
    wrap_up();
  end
  // main sequence
  initial begin
    repeat (10) @(posedge clock_i);
    #1 chk16(status, STATUS_RESET);
    rst_n_i = 1'b1;
    rd_chk(ADDR, REG_STATUS_IDX, 10, 16'hFFFF);
    rd_chk(ADDR, REG_STATUS_IDX, 32, stat(1'b1, 1'b0, 1'b0, 1'b0));
    rd_chk(ADDR, REG_STATUS_IDX, 0, stat(1'b1, 1'b0, 1'b1, 1'b0));
    // link loss, jabber and partner fault pulses
    set_line(7'h36);
    set_line(7'h38);
    rd_chk(ADDR, REG_STATUS_IDX, 0, stat(1'b1, 1'b1, 1'b0, 1'b1));
    rd_chk(ADDR, REG_STATUS_IDX, 0, stat(1'b1, 1'b0, 1'b1, 1'b0));
    // far-end fault pulse
    set_line(7'h39);
    set_line(7'h38);
    rd_chk(ADDR, REG_STATUS_IDX, 0, stat(1'b1, 1'b1, 1'b1, 1'b0));
    rd_chk(ADDR, REG_STATUS_IDX, 0, stat(1'b1, 1'b0, 1'b1, 1'b0));
    // autoneg not done, then autoneg disabled
    set_line(7'h28);
    rd_chk(ADDR, REG_STATUS_IDX, 0, stat(1'b0, 1'b0, 1'b1, 1'b0));
    set_line(7'h18);
    rd_chk(ADDR, REG_STATUS_IDX, 0, stat(1'b0, 1'b0, 1'b1, 1'b0));
    // fiber mode with autoneg done
    set_line(7'h78);
    rd_chk(ADDR, REG_STATUS_IDX, 0, stat(1'b0, 1'b0, 1'b1, 1'b0));
    chk16(status, stat(1'b0, 1'b0, 1'b1, 1'b0));
    // writes are dropped, other places read as documented
    u_mgr.frame(OP_WRITE, ADDR, REG_STATUS_IDX, 16'hFFFF, 0, d);
    u_mgr.frame(OP_WRITE, ADDR, REG_IDENT_HIGH_IDX, ~IDENT, 0, d);
    rd_chk(ADDR, REG_STATUS_IDX, 0, stat(1'b0, 1'b0, 1'b1, 1'b0));
    rd_chk(ADDR, REG_IDENT_HIGH_IDX, 0, IDENT);
    rd_chk(ADDR, 5'h1F, 0, READ_ZERO);
    rd_chk(ADDR ^ 5'h01, REG_STATUS_IDX, 0, 16'hFFFF);
    // hardware reset in mid-run asks for a fresh preamble and clears the link latch
    @(posedge clock_i);
    #1 rst_n_i = 1'b0;
    repeat (10) @(posedge clock_i);
    #1 chk16(status, STATUS_RESET);
    rst_n_i = 1'b1;
    rd_chk(ADDR, REG_STATUS_IDX, 0, 16'hFFFF);
    rd_chk(ADDR, REG_STATUS_IDX, 32, stat(1'b0, 1'b0, 1'b0, 1'b0));
    wrap_up();
  end
endmodule
